//--- src/fsc_pkg.sv
// Package: constants and carrier types for the fast system call unit
package fsc_pkg;

  // Selector offsets added to the enter selector
  localparam logic [15:0] FSC_ENTER_SS_OFS   = 16'h0008;
  localparam logic [15:0] FSC_EXIT32_CS_OFS  = 16'h0010;
  localparam logic [15:0] FSC_EXIT32_SS_OFS  = 16'h0018;
  localparam logic [15:0] FSC_EXIT64_CS_OFS  = 16'h0020;
  localparam logic [15:0] FSC_EXIT64_SS_OFS  = 16'h0028;
  // Selector offsets for fast call / fast return
  localparam logic [15:0] FSC_CALL_SS_OFS    = 16'h0008;
  localparam logic [15:0] FSC_RET64_CS_OFS   = 16'h0010;
  localparam logic [15:0] FSC_RET_SS_OFS     = 16'h0008;

  // Call selector register field positions
  localparam int FSC_CALL_SEL_LSB = 32;
  localparam int FSC_RET_SEL_LSB  = 48;

  // Forced flat segment attributes
  localparam logic [63:0] FSC_FLAT_BASE  = 64'h0000_0000_0000_0000;
  localparam logic [31:0] FSC_FLAT_LIMIT = 32'h0fff_ffff;

  // Privilege levels
  localparam logic [1:0] FSC_CPL_KERNEL = 2'h0;
  localparam logic [1:0] FSC_CPL_USER   = 2'h3;

  // Control register four flag positions
  localparam int FSC_CR4_TSD_BIT = 2;
  localparam int FSC_CR4_PCE_BIT = 4;

  // Feature query answer
  localparam logic [31:0] FSC_FEAT_LEAF     = 32'h8000_0001;
  localparam int          FSC_FEAT_CALL_BIT = 11;

  // Canonical address width
  localparam int FSC_VADDR_BITS = 48;

  // Model register indices
  localparam logic [31:0] FSC_MSR_ENTER_CS  = 32'h0000_0174;
  localparam logic [31:0] FSC_MSR_ENTER_SP  = 32'h0000_0175;
  localparam logic [31:0] FSC_MSR_ENTER_IP  = 32'h0000_0176;
  localparam logic [31:0] FSC_MSR_CALL_SEL  = 32'hc000_0081;
  localparam logic [31:0] FSC_MSR_LONG_TGT  = 32'hc000_0082;
  localparam logic [31:0] FSC_MSR_FLAG_MASK = 32'hc000_0084;

  // Operations presented by the decoder
  typedef enum logic [4:0] {
    FSC_OP_NONE, FSC_OP_ENTER, FSC_OP_EXIT, FSC_OP_CALL, FSC_OP_RET,
    FSC_OP_MODEL_REGISTER_WRITE, FSC_OP_MODEL_REGISTER_READ, FSC_OP_GDT_LD, FSC_OP_LDT_LD, FSC_OP_TR_LD,
    FSC_OP_IDT_LD, FSC_OP_MOV_CR, FSC_OP_MSW_LD, FSC_OP_TS_CLR, FSC_OP_MOV_DR,
    FSC_OP_CACHE_INVALIDATE, FSC_OP_CACHE_WRITEBACK_INVALIDATE, FSC_OP_TLB_ENTRY_INVALIDATE, FSC_OP_HALT, FSC_OP_PERF_COUNTER_READ,
    FSC_OP_TIME_STAMP_READ, FSC_OP_FEAT, FSC_OP_MEM
  } fsc_op_type;

  // Request from the decoder
  typedef struct packed {
    fsc_op_type  op;
    logic        wide;
    logic        long_mode;
    logic        compat_mode;
    logic        prot_mode;
    logic        align_en;
    logic [1:0]  current_privilege_level;
    logic [31:0] cr4;
    logic [63:0] rcx;
    logic [63:0] rdx;
    logic [63:0] rflags;
    logic [63:0] next_rip;
    logic [31:0] msr_idx;
    logic [63:0] msr_data;
    logic [31:0] feat_leaf;
    logic        seg_type_ok;
    logic        seg_rw_ok;
    logic        seg_limit_ok;
    logic        addr_aligned;
  } fsc_req_type;

  // Resulting architectural update
  typedef struct packed {
    logic        fault;
    logic        undef;
    logic        commit;
    logic [1:0]  current_privilege_level;
    logic [15:0] cs_sel;
    logic [15:0] ss_sel;
    logic [63:0] seg_base;
    logic [31:0] seg_limit;
    logic        cs_long;
    logic [63:0] rip;
    logic        rsp_we;
    logic [63:0] rsp;
    logic        rflags_we;
    logic [63:0] rflags;
    logic        rcx_we;
    logic [63:0] rcx;
    logic        r11_we;
    logic [63:0] r11;
    logic [63:0] rd_data;
  } fsc_res_type;

endpackage : fsc_pkg

//--- src/fsc_canon.sv
// Canonical-form checker for a virtual address
`timescale 1ns/1ps
module fsc_canon #(
  parameter int VBITS = 48
) (
  // Address in
  input  wire logic [63:0] addr,
  // Result
  output wire logic        canonical
);
  wire logic [63:VBITS-1] upper = addr[63:VBITS-1];
  // Upper bits must all copy the top implemented bit
  assign canonical = (&upper) | ~(|upper);
endmodule : fsc_canon

//--- src/fsc_unit.sv
// Fast system call unit: privilege transitions, privilege and pointer checks
//
// Contract
// - Fast enter runs at any privilege; fast exit only at privilege 0.
// - Legacy fast enter: selector, pointers from registers; stack selector plus 8.
// - Legacy fast exit: selector plus 16 code, plus 24 stack; EDX, ECX pointers.
// - Fast enter saves nothing; fast exit uses no saved state.
// - Enter forces privilege 0, exit privilege 3; no data memory access.
// - Enter pointer registers are 64 bits; low 32 used outside long mode.
// - Long mode enter: flat base 0, limit FFFFFFF, full 64-bit pointers.
// - Wide fast exit: plus 32 code, plus 40 stack, long bit set, RDX/RCX.
// - 32-bit fast exit: compatibility mode, long bit clear, plus 16/24, EDX/ECX.
// - No fast call or return in compatibility mode; feature bit 11 reports them.
// - Fast call saves flags to R11 and next address to RCX.
// - Fast call code selector from bits 47:32, stack plus 8, long target.
// - Fast call flags become flags AND NOT flag mask.
// - Wide fast return: bits 63:48 plus 16 code, plus 8 stack, RCX, flags.
// - 32-bit fast return: bits 63:48 code, plus 8 stack, ECX, flags.
// - Writing long call target checks canonical form, faults otherwise.
// - Privileged instructions fault when privilege is not 0.
// - Control register four bits 4 and 2 govern counter reads above privilege 0; privilege 0 always reads.
// - Protected mode checks type, rights and limit of memory operands.
// - Alignment checked only at privilege 3 with alignment checking on.
`timescale 1ns/1ps
module fsc_unit (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Decoder request
  input  wire logic               req_valid,
  input  wire fsc_pkg::fsc_req_type req,
  // Result
  output logic                    res_valid,
  output fsc_pkg::fsc_res_type    res
);
  import fsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Model-specific registers
  logic [15:0] enter_sel_q;
  logic [63:0] fast_enter_target_pointer_q;
  logic [63:0] fast_enter_stack_pointer_q;
  logic [63:0] fast_call_selector_base_q;
  logic [63:0] long_mode_call_target_q;
  logic [63:0] flag_mask_q;
  logic        res_valid_q;
  fsc_res_type res_q;
  fsc_res_type res_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic is_priv;
  wire logic ctr_any_pmc;
  wire logic ctr_any_tsc;
  wire logic kernel;
  wire logic priv_fault;
  wire logic msr_canon;
  wire logic lstar_fault;
  wire logic mem_fault;
  wire logic [15:0] call_sel;
  wire logic [15:0] ret_sel;
  wire logic [63:0] enter_ip;
  wire logic [63:0] enter_sp;

  assign kernel      = (req.current_privilege_level == FSC_CPL_KERNEL);
  assign ctr_any_pmc = req.cr4[FSC_CR4_PCE_BIT];
  assign ctr_any_tsc = ~req.cr4[FSC_CR4_TSD_BIT];
  assign is_priv = (req.op inside {FSC_OP_GDT_LD, FSC_OP_LDT_LD, FSC_OP_TR_LD,
                    FSC_OP_IDT_LD, FSC_OP_MOV_CR, FSC_OP_MSW_LD, FSC_OP_TS_CLR,
                    FSC_OP_MOV_DR, FSC_OP_CACHE_INVALIDATE, FSC_OP_CACHE_WRITEBACK_INVALIDATE, FSC_OP_TLB_ENTRY_INVALIDATE,
                    FSC_OP_HALT, FSC_OP_MODEL_REGISTER_READ, FSC_OP_MODEL_REGISTER_WRITE, FSC_OP_EXIT})
                 | ((req.op == FSC_OP_PERF_COUNTER_READ) & ~ctr_any_pmc)
                 | ((req.op == FSC_OP_TIME_STAMP_READ) & ~ctr_any_tsc);
  assign priv_fault = is_priv & ~kernel;

  fsc_canon #(.VBITS(FSC_VADDR_BITS)) u_canon_msr (
    .addr      (req.msr_data),
    .canonical (msr_canon)
  );
  assign lstar_fault = (req.op == FSC_OP_MODEL_REGISTER_WRITE) & (req.msr_idx == FSC_MSR_LONG_TGT)
                     & ~msr_canon;

  // Automatic checks; alignment only in user level with checking on
  assign mem_fault = (req.op == FSC_OP_MEM) & req.prot_mode
                   & (~req.seg_type_ok | ~req.seg_rw_ok | ~req.seg_limit_ok
                      | (req.align_en & (req.current_privilege_level == FSC_CPL_USER)
                         & ~req.addr_aligned));

  assign call_sel = fast_call_selector_base_q[FSC_CALL_SEL_LSB +: 16];
  assign ret_sel  = fast_call_selector_base_q[FSC_RET_SEL_LSB +: 16];
  // Outside long mode only the low halves count
  assign enter_ip = req.long_mode ? fast_enter_target_pointer_q
                  : {32'h0000_0000, fast_enter_target_pointer_q[31:0]};
  assign enter_sp = req.long_mode ? fast_enter_stack_pointer_q
                  : {32'h0000_0000, fast_enter_stack_pointer_q[31:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Result formation
  always_comb begin
    res_d           = '0;
    res_d.current_privilege_level       = req.current_privilege_level;
    res_d.seg_base  = FSC_FLAT_BASE;
    res_d.seg_limit = FSC_FLAT_LIMIT;
    if (priv_fault | lstar_fault | mem_fault) begin
      res_d.fault = 1'b1;
    end else begin
      case (req.op)
        FSC_OP_ENTER: begin
          // Nothing saved for the return path
          res_d.commit = 1'b1;
          res_d.current_privilege_level    = FSC_CPL_KERNEL;
          res_d.cs_sel = enter_sel_q;
          res_d.ss_sel = enter_sel_q + FSC_ENTER_SS_OFS;
          res_d.cs_long = req.long_mode;
          res_d.rip    = enter_ip;
          res_d.rsp_we = 1'b1;
          res_d.rsp    = enter_sp;
        end
        FSC_OP_EXIT: begin
          res_d.commit = 1'b1;
          res_d.current_privilege_level    = FSC_CPL_USER;
          res_d.rsp_we = 1'b1;
          if (req.wide) begin
            res_d.cs_sel  = enter_sel_q + FSC_EXIT64_CS_OFS;
            res_d.ss_sel  = enter_sel_q + FSC_EXIT64_SS_OFS;
            res_d.cs_long = 1'b1;
            res_d.rip     = req.rdx;
            res_d.rsp     = req.rcx;
          end else begin
            res_d.cs_sel  = enter_sel_q + FSC_EXIT32_CS_OFS;
            res_d.ss_sel  = enter_sel_q + FSC_EXIT32_SS_OFS;
            res_d.cs_long = 1'b0;
            res_d.rip     = {32'h0000_0000, req.rdx[31:0]};
            res_d.rsp     = {32'h0000_0000, req.rcx[31:0]};
          end
        end
        FSC_OP_CALL: begin
          if (req.compat_mode | ~req.long_mode) begin
            res_d.undef = 1'b1;
          end else begin
            res_d.commit    = 1'b1;
            res_d.current_privilege_level       = FSC_CPL_KERNEL;
            res_d.r11_we    = 1'b1;
            res_d.r11       = req.rflags;
            res_d.rcx_we    = 1'b1;
            res_d.rcx       = req.next_rip;
            res_d.cs_sel    = call_sel;
            res_d.ss_sel    = call_sel + FSC_CALL_SS_OFS;
            res_d.cs_long   = 1'b1;
            res_d.rip       = long_mode_call_target_q;
            res_d.rflags_we = 1'b1;
            res_d.rflags    = req.rflags & ~flag_mask_q;
          end
        end
        FSC_OP_RET: begin
          // Same privilege gate as fast exit; the return is kernel-only
          if (req.compat_mode | ~req.long_mode) begin
            res_d.undef = 1'b1;
          end else if (!kernel) begin
            res_d.fault = 1'b1;
          end else begin
            res_d.commit    = 1'b1;
            res_d.current_privilege_level       = FSC_CPL_USER;
            res_d.ss_sel    = ret_sel + FSC_RET_SS_OFS;
            res_d.rflags_we = 1'b1;
            res_d.rflags    = req.rflags;
            if (req.wide) begin
              res_d.cs_sel  = ret_sel + FSC_RET64_CS_OFS;
              res_d.cs_long = 1'b1;
              res_d.rip     = req.rcx;
            end else begin
              res_d.cs_sel  = ret_sel;
              res_d.cs_long = 1'b0;
              res_d.rip     = {32'h0000_0000, req.rcx[31:0]};
            end
          end
        end
        FSC_OP_MODEL_REGISTER_READ: begin
          res_d.commit = 1'b1;
          case (req.msr_idx)
            FSC_MSR_ENTER_CS:  res_d.rd_data = {48'h0, enter_sel_q};
            FSC_MSR_ENTER_SP:  res_d.rd_data = fast_enter_stack_pointer_q;
            FSC_MSR_ENTER_IP:  res_d.rd_data = fast_enter_target_pointer_q;
            FSC_MSR_CALL_SEL:  res_d.rd_data = fast_call_selector_base_q;
            FSC_MSR_LONG_TGT:  res_d.rd_data = long_mode_call_target_q;
            FSC_MSR_FLAG_MASK: res_d.rd_data = flag_mask_q;
            default:           res_d.rd_data = '0;
          endcase
        end
        FSC_OP_FEAT: begin
          res_d.commit = 1'b1;
          if (req.feat_leaf == FSC_FEAT_LEAF) begin
            res_d.rd_data[FSC_FEAT_CALL_BIT] = 1'b1;
          end
        end
        FSC_OP_NONE: begin
          res_d.commit = 1'b0;
        end
        default: begin
          res_d.commit = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Model register writes; a faulting write changes nothing
  wire logic msr_we = req_valid & (req.op == FSC_OP_MODEL_REGISTER_WRITE) & kernel & ~lstar_fault;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enter_sel_q                 <= 16'h0000;
      fast_enter_target_pointer_q <= 64'h0;
      fast_enter_stack_pointer_q  <= 64'h0;
      fast_call_selector_base_q   <= 64'h0;
      long_mode_call_target_q     <= 64'h0;
      flag_mask_q                 <= 64'h0;
    end else if (msr_we) begin
      case (req.msr_idx)
        FSC_MSR_ENTER_CS:  enter_sel_q                 <= req.msr_data[15:0];
        FSC_MSR_ENTER_SP:  fast_enter_stack_pointer_q  <= req.msr_data;
        FSC_MSR_ENTER_IP:  fast_enter_target_pointer_q <= req.msr_data;
        FSC_MSR_CALL_SEL:  fast_call_selector_base_q   <= req.msr_data;
        FSC_MSR_LONG_TGT:  long_mode_call_target_q     <= req.msr_data;
        FSC_MSR_FLAG_MASK: flag_mask_q                 <= req.msr_data;
        default:           flag_mask_q                 <= flag_mask_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered result, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      res_q       <= '0;
    end else begin
      res_valid_q <= req_valid;
      res_q       <= res_d;
    end
  end

  assign res_valid = res_valid_q;
  assign res       = res_q;

endmodule : fsc_unit

//--- test/fsc_sva.sv
// Checker for the fast system call unit ports
`timescale 1ns/1ps
module fsc_sva (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // Request and result
  input wire logic                 req_valid,
  input wire fsc_pkg::fsc_req_type req,
  input wire logic                 res_valid,
  input wire fsc_pkg::fsc_res_type res
);
  import fsc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic priv_op = req.op inside {FSC_OP_GDT_LD, FSC_OP_LDT_LD, FSC_OP_TR_LD,
    FSC_OP_IDT_LD, FSC_OP_MOV_CR, FSC_OP_MSW_LD, FSC_OP_TS_CLR, FSC_OP_MOV_DR,
    FSC_OP_CACHE_INVALIDATE, FSC_OP_CACHE_WRITEBACK_INVALIDATE, FSC_OP_TLB_ENTRY_INVALIDATE, FSC_OP_HALT, FSC_OP_MODEL_REGISTER_READ, FSC_OP_MODEL_REGISTER_WRITE};
  wire logic seg_ok = req.seg_type_ok && req.seg_rw_ok && req.seg_limit_ok;
  ////////////////////////////////////////////////////////////////////////////
  resp_pulse_a: assert property (req_valid |=> res_valid)
    else $error("no result after request");
  idle_quiet_a: assert property (!req_valid |=> !res_valid)
    else $error("result without request");
  enter_kernel_a:
    assert property (req_valid && req.op == FSC_OP_ENTER
      |=> !res.fault && res.current_privilege_level == 2'h0 && !res.rcx_we && !res.r11_we)
    else $error("fast enter did not reach privilege 0");
  exit_wide_a:
    assert property (req_valid && req.op == FSC_OP_EXIT && req.current_privilege_level == 2'h0 && req.wide
      && req.long_mode |=> res.cs_long && res.ss_sel == res.cs_sel + 16'h0008
      && res.rip == $past(req.rdx))
    else $error("wide fast exit wrong");
  exit_guard_a:
    assert property (req_valid && req.op == FSC_OP_EXIT && req.current_privilege_level != 2'h0
      |=> res.fault && !res.commit && !res.rsp_we && !res.rflags_we)
    else $error("fast exit above privilege 0 not refused");
  call_save_a:
    assert property (req_valid && req.op == FSC_OP_CALL && req.long_mode && !req.compat_mode
      |=> res.r11_we && res.r11 == $past(req.rflags) && res.rcx == $past(req.next_rip))
    else $error("fast call state save wrong");
  call_compat_a:
    assert property (req_valid && req.op == FSC_OP_CALL && req.compat_mode
      |=> res.undef && !res.commit)
    else $error("fast call ran in compatibility mode");
  priv_fault_a:
    assert property (req_valid && priv_op && req.current_privilege_level != 2'h0 |=> res.fault)
    else $error("privileged op ran above privilege 0");
  tsc_gate_a:
    assert property (req_valid && req.op == FSC_OP_TIME_STAMP_READ && req.current_privilege_level != 2'h0
      |=> res.fault == $past(req.cr4[2]))
    else $error("time stamp read gating wrong");
  pmc_gate_a:
    assert property (req_valid && req.op == FSC_OP_PERF_COUNTER_READ && req.current_privilege_level != 2'h0
      |=> res.fault == !$past(req.cr4[4]))
    else $error("counter read gating wrong");
  align_chk_a:
    assert property (req_valid && req.op == FSC_OP_MEM && req.prot_mode && seg_ok
      |=> res.fault == ($past(req.current_privilege_level) == 2'h3 && $past(req.align_en)
      && !$past(req.addr_aligned)))
    else $error("alignment check wrong");
  flat_seg_a:
    assert property (res_valid && res.commit
      |-> res.seg_base == 64'h0 && res.seg_limit == 32'h0fff_ffff)
    else $error("segment not flat");
endmodule : fsc_sva
bind fsc_unit fsc_sva u_sva (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
  .req(req), .res_valid(res_valid), .res(res));

//--- test/fsc_sw_model.sv
// Software-side model issuing one decoded instruction at a time
`timescale 1ns/1ps
module fsc_sw_model (
  // Clock
  input wire logic                  sys_clk,
  // Request to the unit
  output logic                      req_valid,
  output fsc_pkg::fsc_req_type      req,
  // Result from the unit
  input wire logic                  res_valid,
  input wire fsc_pkg::fsc_res_type  res
);
  import fsc_pkg::*;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Held to the taking edge; fields inverted after so stale values never match
  task automatic issue(input fsc_req_type r, output fsc_res_type s, output logic v);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req = r;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    req = ~r;
    v = res_valid;
    s = res;
  endtask : issue
endmodule : fsc_sw_model

//--- test/tb_top.sv
// Testbench for the fast system call unit
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  localparam logic [63:0] EIP = 64'hffff_8000_1234_5678;
  localparam logic [63:0] ESP = 64'hffff_8000_0000_9ab0;
  localparam logic [63:0] STAR = 64'h0023_0010_0000_0000;
  localparam logic [63:0] LTGT = 64'hffff_8000_0000_4000;
  localparam logic [63:0] FMSK = 64'h0000_0000_0000_0300;
  logic        sys_clk, rst, req_valid, res_valid, v;
  fsc_req_type req, q;
  fsc_res_type res, s;
  int          bad_count, check_count;
  fsc_op_type  pops[14] = '{FSC_OP_GDT_LD, FSC_OP_LDT_LD, FSC_OP_TR_LD, FSC_OP_IDT_LD,
    FSC_OP_MOV_CR, FSC_OP_MSW_LD, FSC_OP_TS_CLR, FSC_OP_MOV_DR, FSC_OP_CACHE_INVALIDATE,
    FSC_OP_CACHE_WRITEBACK_INVALIDATE, FSC_OP_TLB_ENTRY_INVALIDATE, FSC_OP_HALT, FSC_OP_MODEL_REGISTER_READ, FSC_OP_MODEL_REGISTER_WRITE};
  fsc_unit dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .res_valid(res_valid), .res(res));
  fsc_sw_model sw (.sys_clk(sys_clk), .req_valid(req_valid), .req(req),
    .res_valid(res_valid), .res(res));
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input fsc_op_type op);
    q.op = op;
    sw.issue(q, s, v);
    chk(v, 1'b1);
  endtask : run
  task automatic wr(input logic [31:0] i, input logic [63:0] d);
    q = '0;
    q.msr_idx = i;
    q.msr_data = d;
    run(FSC_OP_MODEL_REGISTER_WRITE);
  endtask : wr
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    #50000;
    bad_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    q = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    q.msr_idx = FSC_MSR_LONG_TGT;
    run(FSC_OP_MODEL_REGISTER_READ);
    chk(s.rd_data, 64'h0);
    wr(FSC_MSR_ENTER_CS, 64'h10);
    wr(FSC_MSR_ENTER_IP, EIP);
    wr(FSC_MSR_ENTER_SP, ESP);
    wr(FSC_MSR_CALL_SEL, STAR);
    wr(FSC_MSR_FLAG_MASK, FMSK);
    wr(FSC_MSR_LONG_TGT, LTGT);
    chk(s.fault, 1'b0);
    wr(FSC_MSR_LONG_TGT, 64'h0001_0000_0000_0000);
    chk(s.fault, 1'b1);
    run(FSC_OP_MODEL_REGISTER_READ);
    chk(s.rd_data, LTGT);
    $display("test registers done");
    q = '0;
    q.current_privilege_level = FSC_CPL_USER;
    run(FSC_OP_ENTER);
    chk({s.cs_sel, s.ss_sel}, 32'h0010_0018);
    chk(s.rip, {32'h0, EIP[31:0]});
    chk(s.rsp, {32'h0, ESP[31:0]});
    chk({s.current_privilege_level, s.rcx_we, s.r11_we}, 4'h0);
    q.long_mode = 1'b1;
    run(FSC_OP_ENTER);
    chk(s.rip, EIP);
    chk(s.rsp, ESP);
    chk(s.seg_base, 64'h0);
    chk(s.seg_limit, 32'h0fff_ffff);
    $display("test enter done");
    q = '0;
    q.rdx = 64'h1111_2222_3333_4444;
    q.rcx = 64'h5555_6666_7777_8888;
    run(FSC_OP_EXIT);
    chk({s.cs_sel, s.ss_sel}, 32'h0020_0028);
    chk({s.rip[31:0], s.rsp[31:0]}, 64'h3333_4444_7777_8888);
    chk(s.current_privilege_level, FSC_CPL_USER);
    q.long_mode = 1'b1;
    q.wide = 1'b1;
    run(FSC_OP_EXIT);
    chk({s.cs_sel, s.ss_sel, 31'h0, s.cs_long}, 64'h0030_0038_0000_0001);
    chk(s.rip, q.rdx);
    chk(s.rsp, q.rcx);
    q.wide = 1'b0;
    run(FSC_OP_EXIT);
    chk({s.cs_sel, s.ss_sel, 31'h0, s.cs_long}, 64'h0020_0028_0000_0000);
    chk(s.rip[31:0], 32'h3333_4444);
    q.current_privilege_level = FSC_CPL_USER;
    run(FSC_OP_EXIT);
    chk({s.fault, s.commit, s.rsp_we, s.rflags_we}, 4'b1000);
    $display("test exit done");
    q = '0;
    q.long_mode = 1'b1;
    q.current_privilege_level = FSC_CPL_USER;
    q.rflags = 64'h346;
    q.next_rip = 64'h0000_7fff_0000_1000;
    run(FSC_OP_CALL);
    chk({s.cs_sel, s.ss_sel}, 32'h0010_0018);
    chk(s.rip, LTGT);
    chk(s.r11, 64'h346);
    chk(s.rcx, q.next_rip);
    chk(s.rflags, 64'h046);
    q.compat_mode = 1'b1;
    run(FSC_OP_CALL);
    chk({s.undef, s.commit}, 2'b10);
    q = '0;
    q.long_mode = 1'b1;
    q.wide = 1'b1;
    q.rcx = 64'h0000_7fff_0000_2000;
    q.rflags = 64'h202;
    run(FSC_OP_RET);
    chk({s.cs_sel, s.ss_sel}, 32'h0033_002b);
    chk(s.rip, q.rcx);
    chk(s.rflags, 64'h202);
    q.wide = 1'b0;
    run(FSC_OP_RET);
    chk({s.cs_sel, s.ss_sel}, 32'h0023_002b);
    chk(s.rip, 64'h0000_0000_0000_2000);
    chk(s.rflags, 64'h202);
    q.compat_mode = 1'b1;
    run(FSC_OP_RET);
    chk({s.undef, s.commit}, 2'b10);
    q = '0;
    q.feat_leaf = FSC_FEAT_LEAF;
    run(FSC_OP_FEAT);
    chk(s.rd_data[11], 1'b1);
    q.feat_leaf = 32'h0000_0000;
    run(FSC_OP_FEAT);
    chk(s.rd_data, 64'h0);
    $display("test call return done");
    q.msr_idx = FSC_MSR_FLAG_MASK;
    q.msr_data = FMSK;
    foreach (pops[i]) begin
      q.current_privilege_level = FSC_CPL_USER;
      run(pops[i]);
      chk(s.fault, 1'b1);
      q.current_privilege_level = FSC_CPL_KERNEL;
      run(pops[i]);
      chk(s.fault, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      q.current_privilege_level = FSC_CPL_USER;
      q.cr4 = {27'h0, k[1], 1'b0, k[0], 2'b0};
      run(FSC_OP_TIME_STAMP_READ);
      chk(s.fault, k[0]);
      run(FSC_OP_PERF_COUNTER_READ);
      chk(s.fault, !k[1]);
    end
    $display("test privilege done");
    q = '0;
    q.op = FSC_OP_MEM;
    q.prot_mode = 1'b1;
    for (int j = 0; j < 4; j++) begin
      {q.seg_type_ok, q.seg_rw_ok, q.seg_limit_ok} = ~(3'b1 << j);
      run(FSC_OP_MEM);
      chk(s.fault, j < 3);
    end
    q.align_en = 1'b1;
    q.current_privilege_level = FSC_CPL_USER;
    run(FSC_OP_MEM);
    chk(s.fault, 1'b1);
    q.current_privilege_level = FSC_CPL_KERNEL;
    run(FSC_OP_MEM);
    chk(s.fault, 1'b0);
    q.current_privilege_level = FSC_CPL_USER;
    q.addr_aligned = 1'b1;
    run(FSC_OP_MEM);
    chk(s.fault, 1'b0);
    q.addr_aligned = 1'b0;
    q.align_en = 1'b0;
    run(FSC_OP_MEM);
    chk(s.fault, 1'b0);
    $display("test pointer checks done");
    stop_test();
  end
endmodule : tb_top
